// *** verilog/scr_defines.svh ***
// constants for the serializer control register bank
// assumes inclusion by bare name from the design files
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH
`define SCR_ADDR_CLK_DELAY   8'h24
`define SCR_ADDR_POWER       8'h26
`define SCR_ADDR_ERR_MASK    8'h27
`define SCR_ADDR_LOSS_OVR    8'h28
`define SCR_ADDR_LOSS_STAT   8'h29
`define SCR_BIT_BYPASS       7
`define SCR_BIT_CHAN_RST     7
`define SCR_PD_MSB           6
`define SCR_PD_RESET         7'h3f
`define SCR_PD_NORMAL        7'h3f
`define SCR_PD_LOWPWR        7'h40
`define SCR_BIT_PLL_MASK     4
`define SCR_BIT_FIFO_MASK    3
`define SCR_BIT_CLKDET_MASK  2
`define SCR_BIT_CLKLOS_MASK  1
`define SCR_BIT_LANE_MASK    0
`define SCR_MASK_MSB         4
`define SCR_BIT_FORCE_LOW    1
`define SCR_BIT_FORCE_HIGH   0
`define SCR_LANES            5
`define SCR_CNT_W            16
`define SCR_CNT_MAX          16'hffff
`define SCR_NUM_ERR          5
`endif

// *** verilog/scr_pkg.sv ***
// types shared by the serializer control register bank
// assumes nothing beyond a SystemVerilog compiler
package scr_pkg;
  typedef logic [7:0]  scr_byte_t;
  typedef logic [15:0] scr_cnt_t;
endpackage

// *** verilog/scr_err_counter.sv ***
// one saturating error event counter with a mask input
// assumes events are single-cycle pulses synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
`include "scr_defines.svh"
module scr_err_counter
  import scr_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic event_pulse,
  input  wire logic event_mask,
  output scr_cnt_t  count
);
  scr_cnt_t count_ff;
  scr_cnt_t nxt_count;
  wire      do_count = event_pulse & ~event_mask;
  // saturate rather than wrap so a long fault never reads as few errors
  assign nxt_count = (do_count && count_ff != `SCR_CNT_MAX) ?
                     scr_cnt_t'(count_ff + 16'h0001) : count_ff;
  always_ff @(posedge mclk) begin
    if (rst) count_ff <= '0;
    else     count_ff <= nxt_count;
  end
  assign count = count_ff;
endmodule
`default_nettype wire

// *** verilog/scr_regs.sv ***
// register bank: clock bypass, power/channel reset, error masks, loss override
// assumes a management bus front end presenting byte writes and reads on mclk
//
// Function
// - reg 0x24 bit 7 bypasses input clock delay; resets to zero
// - reg 0x26 bit 7 drives the serializer channel reset
// - seven-bit power-down field resets to 0x3f; 0x3f normal, 0x40 low power
// - error events are counted per type in internal counters
// - mask bits in 0x27 stop counting; bit4 pll, bit0 lane loss
// - mask bit 3 excludes buffer overflow and underflow errors
// - mask bit 2 excludes input clock detection errors
// - mask bit 1 excludes clock loss errors
// - override bit 1 forces loss indicator low
// - override bit 0 forces it high, winning over bit 1
// - one status bit per lane, one means no data present
`timescale 1ns/1ps
`default_nettype none
`include "scr_defines.svh"
module scr_regs
  import scr_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic [7:0]               bus_addr,
  input  wire logic                     bus_wr,
  input  wire logic                     bus_rd,
  input  wire logic [7:0]               bus_wdata,
  output scr_byte_t                     bus_rdata,
  input  wire logic [`SCR_LANES-1:0]    lane_absent_raw,
  input  wire logic                     clock_absent_raw,
  input  wire logic [`SCR_NUM_ERR-1:0]  err_events,
  output logic                          clk_delay_bypass,
  output logic                          channel_reset,
  output logic [`SCR_PD_MSB:0]          power_down,
  output logic                          signal_loss_indicator,
  output logic [`SCR_LANES-1:0]         lane_absent_flags,
  output logic [`SCR_NUM_ERR-1:0]       err_nonzero
);
  // ==========================================================
  // register storage
  logic                     bypass_ff;
  logic                     chan_rst_ff;
  logic [`SCR_PD_MSB:0]     pd_ff;
  logic [`SCR_MASK_MSB:0]   mask_ff;
  logic                     force_low_ff;
  logic                     force_high_ff;
  wire  wr_clk  = bus_wr & (bus_addr == `SCR_ADDR_CLK_DELAY);
  wire  wr_pwr  = bus_wr & (bus_addr == `SCR_ADDR_POWER);
  wire  wr_mask = bus_wr & (bus_addr == `SCR_ADDR_ERR_MASK);
  wire  wr_ovr  = bus_wr & (bus_addr == `SCR_ADDR_LOSS_OVR);
  always_ff @(posedge mclk) begin
    if (rst) begin
      bypass_ff     <= 1'b0;
      chan_rst_ff   <= 1'b0;
      pd_ff         <= `SCR_PD_RESET;
      mask_ff       <= '0;
      force_low_ff  <= 1'b0;
      force_high_ff <= 1'b0;
    end else begin
      // only documented bits are stored, the rest are dropped
      if (wr_clk)  bypass_ff   <= bus_wdata[`SCR_BIT_BYPASS];
      if (wr_pwr)  chan_rst_ff <= bus_wdata[`SCR_BIT_CHAN_RST];
      if (wr_pwr)  pd_ff       <= bus_wdata[`SCR_PD_MSB:0];
      if (wr_mask) mask_ff     <= bus_wdata[`SCR_MASK_MSB:0];
      if (wr_ovr)  force_low_ff  <= bus_wdata[`SCR_BIT_FORCE_LOW];
      if (wr_ovr)  force_high_ff <= bus_wdata[`SCR_BIT_FORCE_HIGH];
    end
  end
  // ==========================================================
  // error counters, one per event type
  // events: 4 pll, 3 fifo over/underflow, 2 clock detect, 1 clock loss, 0 lane loss
  scr_cnt_t cnt [`SCR_NUM_ERR];
  genvar gi;
  generate
    for (gi = 0; gi < `SCR_NUM_ERR; gi++) begin : g_cnt
      scr_err_counter u_cnt (
        .mclk        (mclk),
        .rst         (rst),
        .event_pulse (err_events[gi]),
        .event_mask  (mask_ff[gi]),
        .count       (cnt[gi])
      );
    end
  endgenerate
  // ==========================================================
  // loss indicator and status
  wire any_loss = clock_absent_raw | (|lane_absent_raw);
  // force high has priority over force low
  wire nxt_loss = force_high_ff ? 1'b1 : (force_low_ff ? 1'b0 : any_loss);
  logic                  loss_ff;
  logic [`SCR_LANES-1:0] lane_ff;
  logic [`SCR_NUM_ERR-1:0] nz_ff;
  logic [`SCR_NUM_ERR-1:0] nxt_nz;
  scr_byte_t rdata_ff;
  scr_byte_t nxt_rdata;
  generate
    for (gi = 0; gi < `SCR_NUM_ERR; gi++) begin : g_nz
      assign nxt_nz[gi] = (cnt[gi] != '0);
    end
  endgenerate
  wire [7:0] rd_clk  = {bypass_ff, 7'h00};
  wire [7:0] rd_pwr  = {chan_rst_ff, pd_ff};
  wire [7:0] rd_mask = {3'h0, mask_ff};
  wire [7:0] rd_ovr  = {6'h00, force_low_ff, force_high_ff};
  wire [7:0] rd_stat = {2'h0, clock_absent_raw, lane_absent_raw};
  // unmapped addresses read zero
  assign nxt_rdata = (bus_addr == `SCR_ADDR_CLK_DELAY) ? rd_clk  :
                     (bus_addr == `SCR_ADDR_POWER)     ? rd_pwr  :
                     (bus_addr == `SCR_ADDR_ERR_MASK)  ? rd_mask :
                     (bus_addr == `SCR_ADDR_LOSS_OVR)  ? rd_ovr  :
                     (bus_addr == `SCR_ADDR_LOSS_STAT) ? rd_stat : 8'h00;
  always_ff @(posedge mclk) begin
    if (rst) begin
      loss_ff  <= 1'b0;
      lane_ff  <= '0;
      nz_ff    <= '0;
      rdata_ff <= 8'h00;
    end else begin
      loss_ff  <= nxt_loss;
      lane_ff  <= lane_absent_raw;
      nz_ff    <= nxt_nz;
      if (bus_rd) rdata_ff <= nxt_rdata;
    end
  end
  assign bus_rdata             = rdata_ff;
  assign clk_delay_bypass      = bypass_ff;
  assign channel_reset         = chan_rst_ff;
  assign power_down            = pd_ff;
  assign signal_loss_indicator = loss_ff;
  assign lane_absent_flags     = lane_ff;
  assign err_nonzero           = nz_ff;
  // ==========================================================
  // checks
  sequence s_force_high;
    force_high_ff;
  endsequence
  sequence s_force_low_only;
    force_low_ff && !force_high_ff;
  endsequence
  chk_force_high_wins: assert property (@(posedge mclk) disable iff (rst)
    s_force_high |=> signal_loss_indicator) else $error("force high not seen");
  chk_force_low_path: assert property (@(posedge mclk) disable iff (rst)
    s_force_low_only |=> !signal_loss_indicator) else $error("force low not seen");
  chk_loss_follows: assert property (@(posedge mclk) disable iff (rst)
    (!force_high_ff && !force_low_ff) |=> signal_loss_indicator == $past(any_loss))
    else $error("loss indicator not following inputs");
  chk_bypass_write: assert property (@(posedge mclk) disable iff (rst)
    wr_clk |=> clk_delay_bypass == $past(bus_wdata[`SCR_BIT_BYPASS]))
    else $error("bypass write lost");
  chk_chan_rst_write: assert property (@(posedge mclk) disable iff (rst)
    wr_pwr |=> channel_reset == $past(bus_wdata[`SCR_BIT_CHAN_RST]))
    else $error("channel reset write lost");
  chk_pd_reset_val: assert property (@(posedge mclk)
    rst |=> power_down == `SCR_PD_RESET) else $error("power-down reset value wrong");
  chk_masked_hold: assert property (@(posedge mclk) disable iff (rst)
    (mask_ff[`SCR_BIT_FIFO_MASK] && err_events[`SCR_BIT_FIFO_MASK]) |=>
    $stable(cnt[`SCR_BIT_FIFO_MASK])) else $error("masked fifo error counted");
  chk_clkdet_hold: assert property (@(posedge mclk) disable iff (rst)
    (mask_ff[`SCR_BIT_CLKDET_MASK] && err_events[`SCR_BIT_CLKDET_MASK]) |=>
    $stable(cnt[`SCR_BIT_CLKDET_MASK])) else $error("masked detect error counted");
  chk_clklos_hold: assert property (@(posedge mclk) disable iff (rst)
    (mask_ff[`SCR_BIT_CLKLOS_MASK] && err_events[`SCR_BIT_CLKLOS_MASK]) |=>
    $stable(cnt[`SCR_BIT_CLKLOS_MASK])) else $error("masked clock loss counted");
  chk_unmasked_count: assert property (@(posedge mclk) disable iff (rst)
    (!mask_ff[`SCR_BIT_LANE_MASK] && err_events[`SCR_BIT_LANE_MASK] &&
     cnt[`SCR_BIT_LANE_MASK] != `SCR_CNT_MAX) |=>
    cnt[`SCR_BIT_LANE_MASK] == $past(cnt[`SCR_BIT_LANE_MASK]) + 16'h0001)
    else $error("lane loss not counted");
  chk_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
    (bus_rd && bus_addr == `SCR_ADDR_CLK_DELAY) |=> bus_rdata[6:0] == 7'h00)
    else $error("reserved bits not zero");
  chk_lane_status: assert property (@(posedge mclk) disable iff (rst)
    1'b1 |=> lane_absent_flags == $past(lane_absent_raw))
    else $error("lane flags stale");
  // ==========================================================
  // mask, write, read and reset checks
  // the pll and lane-loss masks get their own hold checks: a swapped
  // mask index would still pass the fifo, detect and clock-loss checks
  sequence s_ovr_write;
    wr_ovr;
  endsequence
  chk_pll_hold: assert property (@(posedge mclk) disable iff (rst)
    (mask_ff[`SCR_BIT_PLL_MASK] && err_events[`SCR_BIT_PLL_MASK]) |=>
    $stable(cnt[`SCR_BIT_PLL_MASK])) else $error("masked pll error counted");
  chk_lane_hold: assert property (@(posedge mclk) disable iff (rst)
    (mask_ff[`SCR_BIT_LANE_MASK] && err_events[`SCR_BIT_LANE_MASK]) |=>
    $stable(cnt[`SCR_BIT_LANE_MASK])) else $error("masked lane loss counted");
  chk_nz_lane: assert property (@(posedge mclk) disable iff (rst)
    (cnt[`SCR_BIT_LANE_MASK] != '0) |=> err_nonzero[`SCR_BIT_LANE_MASK])
    else $error("lane loss count not flagged");
  chk_pd_write: assert property (@(posedge mclk) disable iff (rst)
    wr_pwr |=> power_down == $past(bus_wdata[`SCR_PD_MSB:0]))
    else $error("power-down write lost");
  chk_mask_write: assert property (@(posedge mclk) disable iff (rst)
    wr_mask |=> rd_mask == {3'h0, $past(bus_wdata[`SCR_MASK_MSB:0])})
    else $error("mask write lost");
  chk_ovr_write: assert property (@(posedge mclk) disable iff (rst)
    s_ovr_write |=> rd_ovr == {6'h00, $past(bus_wdata[`SCR_BIT_FORCE_LOW:`SCR_BIT_FORCE_HIGH])})
    else $error("override write lost");
  // read data must hold between reads so a slow host still sees its answer
  chk_rdata_hold: assert property (@(posedge mclk) disable iff (rst)
    !bus_rd |=> $stable(bus_rdata)) else $error("read data changed without a read");
  chk_rd_unmapped: assert property (@(posedge mclk) disable iff (rst)
    (bus_rd && !(bus_addr inside {`SCR_ADDR_CLK_DELAY, `SCR_ADDR_POWER, `SCR_ADDR_ERR_MASK,
      `SCR_ADDR_LOSS_OVR, `SCR_ADDR_LOSS_STAT})) |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_stat_read: assert property (@(posedge mclk) disable iff (rst)
    (bus_rd && bus_addr == `SCR_ADDR_LOSS_STAT) |=>
    bus_rdata == {2'h0, $past(clock_absent_raw), $past(lane_absent_raw)})
    else $error("status read wrong");
  // reset values, checked on the edge after any reset cycle
  chk_ctrl_reset: assert property (@(posedge mclk)
    rst |=> !clk_delay_bypass && !channel_reset) else $error("control reset value wrong");
  chk_mask_reset: assert property (@(posedge mclk)
    rst |=> rd_mask == 8'h00) else $error("mask reset value wrong");
  chk_ovr_reset: assert property (@(posedge mclk)
    rst |=> rd_ovr == 8'h00 && !signal_loss_indicator) else $error("override reset wrong");
  chk_flags_reset: assert property (@(posedge mclk)
    rst |=> lane_absent_flags == '0 && err_nonzero == '0) else $error("status reset wrong");
endmodule
`default_nettype wire

// *** verif/scr_host_model.sv ***
// host model: byte writes and reads on the management bus, one at a time
// assumes the register bank answers a read one cycle after taking it
`timescale 1ns/1ps
`default_nettype none
module scr_host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] bus_rdata,
  output logic [7:0]      bus_addr,
  output logic            bus_wr,
  output logic            bus_rd,
  output logic [7:0]      bus_wdata,
  output logic            rd_valid,
  output logic [7:0]      rd_data
);
  initial {bus_addr, bus_wr, bus_rd, bus_wdata, rd_valid, rd_data} = '0;
  // strobes drop for a cycle so back-to-back calls never touch them twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'h1;
    @(posedge mclk);
    bus_wr <= 1'h0;
    bus_wdata <= ~d;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    bus_addr <= a;
    bus_rd <= 1'h1;
    @(posedge mclk);
    bus_rd <= 1'h0;
    @(posedge mclk);
    rd_data <= bus_rdata;
    rd_valid <= 1'h1;
    @(posedge mclk);
    rd_valid <= 1'h0;
  endtask
endmodule
`default_nettype wire

// *** verif/serializer_control_registers_tb.sv ***
// self-checking bench for the serializer control register bank
// assumes scr_regs as top with the host model on its bus
`timescale 1ns/1ps
`default_nettype none
module serializer_control_registers_tb;
  logic        mclk = 1'h0;
  logic        rst = 1'h1;
  logic [4:0]  lane_raw = 5'h00;
  logic        clk_raw = 1'h0;
  logic [4:0]  events = 5'h00;
  wire logic [7:0] addr, wdata, rdata, rd_data;
  wire logic       wr, rd, rd_valid, bypass, chan_rst, loss;
  wire logic [6:0] pd;
  wire logic [4:0] flags, nonzero;
  logic [7:0]  exp_q [$];
  logic [15:0] seed = 16'h9106;
  logic [7:0]  ra [5] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28};
  logic [7:0]  rb [5] = '{8'h80, 8'h00, 8'hff, 8'h1f, 8'h03};
  logic [7:0]  pv [4] = '{8'hc0, 8'h40, 8'hbf, 8'h3f};
  logic [7:0]  mk;
  logic [4:0]  acc = 5'h00;
  logic [1:0]  ov;
  logic        expl;
  int          n_fail = 0, comparisons = 0, cycles = 0;
  always #5 mclk = ~mclk;
  scr_host_model host (.mclk(mclk), .bus_rdata(rdata), .bus_addr(addr), .bus_wr(wr),
    .bus_rd(rd), .bus_wdata(wdata), .rd_valid(rd_valid), .rd_data(rd_data));
  scr_regs dut (.mclk(mclk), .rst(rst), .bus_addr(addr), .bus_wr(wr), .bus_rd(rd),
    .bus_wdata(wdata), .bus_rdata(rdata), .lane_absent_raw(lane_raw),
    .clock_absent_raw(clk_raw), .err_events(events), .clk_delay_bypass(bypass),
    .channel_reset(chan_rst), .power_down(pd), .signal_loss_indicator(loss),
    .lane_absent_flags(flags), .err_nonzero(nonzero));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t output %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  // outputs may lag a write by up to two edges; look once they have settled
  task automatic look;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic stop_test;
    $display("failures %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (rd_valid === 1'h1 && exp_q.size() > 0) chk_rd(rd_data, exp_q.pop_front());
    if (cycles == 3000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'h0;
    foreach (ra[i]) rd_chk(ra[i], (ra[i] == 8'h26) ? 8'h3f : 8'h00);
    foreach (ra[i]) begin
      host.wr(ra[i], 8'hff);
      rd_chk(ra[i], rb[i]);
    end
    look;
    chk_out({bypass, chan_rst, loss, 5'h00}, 8'he0);
    @(posedge mclk);
    for (int k = 0; k < 12; k++) begin
      seed = lfsr(seed);
      ov = k[1:0];
      lane_raw <= seed[4:0];
      clk_raw <= seed[5];
      host.wr(8'h28, {6'h00, ov});
      expl = ov[0] | (!ov[1] & (seed[5] | (seed[4:0] != 5'h00)));
      look;
      chk_out({2'h0, loss, flags}, {2'h0, expl, seed[4:0]});
      @(posedge mclk);
      rd_chk(8'h29, {2'h0, seed[5:0]});
    end
    foreach (pv[i]) begin
      host.wr(8'h26, pv[i]);
      look;
      chk_out({chan_rst, pd}, pv[i]);
      @(posedge mclk);
    end
    for (int m = 0; m < 3; m++) begin
      seed = lfsr(seed);
      mk = (m == 0) ? 8'hff : (m == 1) ? seed[7:0] : 8'h00;
      host.wr(8'h27, mk);
      events <= 5'h1f;
      @(posedge mclk);
      events <= 5'h00;
      look;
      acc = acc | ~mk[4:0];
      chk_out({3'h0, nonzero}, {3'h0, acc});
      @(posedge mclk);
    end
    stop_test;
  end
endmodule
`default_nettype wire
